// ===== eirq_defs.svh
// Offsets, field positions, reset values and vector addresses of the interrupt controller
`ifndef EIRQ_DEFS_SVH
`define EIRQ_DEFS_SVH

// Register byte addresses
`define EIRQ_OFS_IE      8'hA8
`define EIRQ_OFS_IE_SET  8'hAC
`define EIRQ_OFS_IE_CLR  8'hB0
`define EIRQ_OFS_LVL_LO  8'hB8
`define EIRQ_OFS_LVL_HI  8'hBC
`define EIRQ_OFS_IE1     8'hC0
`define EIRQ_OFS_STATUS  8'hD0
`define EIRQ_OFS_MASK    8'hD4
`define EIRQ_OFS_ACTIVE  8'hD8

// Enable register fields
`define EIRQ_IE_GATE     7
`define EIRQ_IE_PCA      6
`define EIRQ_IE_UART     4
`define EIRQ_IE_TMR1     3
`define EIRQ_IE_EXT1     2
`define EIRQ_IE_TMR0     1
`define EIRQ_IE_EXT0     0
`define EIRQ_IE_WMASK    8'hDF
`define EIRQ_IE1_SPI     2
`define EIRQ_IE1_CONV    1

// Reset values
`define EIRQ_IE_RST      8'h00
`define EIRQ_IE1_RST     2'h0
`define EIRQ_LVL_RST     8'h00
`define EIRQ_STAT_RST    8'h00
`define EIRQ_MASK_RST    8'h00

// Vector addresses, by polling index
`define EIRQ_VEC_EXT0    16'h0003
`define EIRQ_VEC_TMR0    16'h000B
`define EIRQ_VEC_EXT1    16'h0013
`define EIRQ_VEC_TMR1    16'h001B
`define EIRQ_VEC_PCA     16'h0033
`define EIRQ_VEC_UART    16'h0023
`define EIRQ_VEC_SPI     16'h004B
`define EIRQ_VEC_CONV    16'h0043

// Bus responses
`define EIRQ_RESP_OKAY   2'h0
`define EIRQ_RESP_SLVERR 2'h2

`endif

// ===== eirq_pkg.sv
// Types shared by the interrupt controller modules
package eirq_pkg;

   // Register bus slave states, Gray coded from idle
   typedef enum logic [1:0]
   {
      AX_IDLE = 2'h0,
      AX_WRSP = 2'h1,
      AX_RDAT = 2'h2
   } eirq_axi_e;

   // Whole state of the controller
   typedef struct packed
   {
      logic        ext0_s1;
      logic        ext0_s2;
      logic        ext1_s1;
      logic        ext1_s2;
      logic [7:0]  ie;
      logic [1:0]  ie1;
      logic [7:0]  lvl_lo;
      logic [7:0]  lvl_hi;
      logic [7:0]  status;
      logic [7:0]  mask;
      logic [3:0]  in_service;
      logic        req;
      logic [2:0]  src;
      logic [1:0]  level;
      logic [15:0] vector;
      eirq_axi_e   ax;
      logic        aw_got;
      logic        w_got;
      logic [7:0]  awaddr;
      logic [31:0] wdata;
      logic [3:0]  wstrb;
      logic [31:0] rdata;
      logic [1:0]  resp;
   } eirq_state_s;

endpackage

// ===== eirq_pick.sv
// Winner selection among enabled requests: level first, then polling index
`timescale 1ns/1ps
module eirq_pick
   import eirq_pkg::*;
(
   // Requests, by polling index
   input  wire logic [7:0] req,
   // Level bits, by polling index
   input  wire logic [7:0] lvl_lo,
   input  wire logic [7:0] lvl_hi,
   // Winner
   output logic            win_valid,
   output logic [2:0]      win_idx,
   output logic [1:0]      win_level
);

   // Scan from the last index down so the lowest index wins a tie
   always_comb
   begin
      win_valid = 1'b0;
      win_idx   = 3'h0;
      win_level = 2'h0;
      for (int i = 7; i >= 0; i--)
      begin
         // Level is formed from high and low bits
         if (req[i] && (!win_valid || ({lvl_hi[i], lvl_lo[i]} >= win_level))) // R04 R06 R07 R08
         begin
            win_valid = 1'b1;
            win_idx   = 3'(i);
            win_level = {lvl_hi[i], lvl_lo[i]};
         end
      end
   end

endmodule

// ===== eirq_ctrl.sv
// Eight source interrupt controller with register bus slave and core vector port
`timescale 1ns/1ps
`include "eirq_defs.svh"

// Function
// R01 - Accept eight request sources
// R02 - Disabled source is never taken; code can still take the offer already standing in the cycle its enable clears
// R03 - Cleared global gate blocks every interrupt; code gates only core_irq_req, irq still follows status and mask
// R04 - Level is high bit then low bit
// R05 - Only strictly higher level preempts running handler
// R06 - Higher level wins simultaneous requests
// R07 - Fixed polling breaks ties within level
// R08 - Polling order ext0 tmr0 ext1 tmr1 pca uart spi conv
// R09 - Fixed vector address per source
// R10 - Enable register bit layout as documented
// R11 - Enables clear at reset; single-bit access
// R12 - Software never sets the reserved bit
// R13 - Second enable register holds spi, conv
// R14 - Present vector, level; track active levels
module eirq_ctrl
   import eirq_pkg::*;
(
   // Clock and reset
   input  wire logic        sys_clk,
   input  wire logic        reset,
   // Request sources
   input  wire logic        ext_pin0_req,
   input  wire logic        ext_pin1_req,
   input  wire logic        tmr0_ovf_flag,
   input  wire logic        tmr1_ovf_flag,
   input  wire logic        pca_count_wrap_flag,
   input  wire logic        pca_module_match_flag,
   input  wire logic        uart_rx_done,
   input  wire logic        uart_tx_done,
   input  wire logic        spi_req,
   input  wire logic        conv_req,
   // Core vector port
   output logic             core_irq_req,
   output logic [15:0]      core_vector,
   output logic [1:0]       core_level,
   output logic [2:0]       core_src,
   input  wire logic        core_ack,
   input  wire logic        core_reti,
   // Interrupt output
   output logic             irq,
   // Register bus write address
   input  wire logic [7:0]  s_axi_awaddr,
   input  wire logic        s_axi_awvalid,
   output logic             s_axi_awready,
   // Register bus write data
   input  wire logic [31:0] s_axi_wdata,
   input  wire logic [3:0]  s_axi_wstrb,
   input  wire logic        s_axi_wvalid,
   output logic             s_axi_wready,
   // Register bus write response
   output logic [1:0]       s_axi_bresp,
   output logic             s_axi_bvalid,
   input  wire logic        s_axi_bready,
   // Register bus read address
   input  wire logic [7:0]  s_axi_araddr,
   input  wire logic        s_axi_arvalid,
   output logic             s_axi_arready,
   // Register bus read data
   output logic [31:0]      s_axi_rdata,
   output logic [1:0]       s_axi_rresp,
   output logic             s_axi_rvalid,
   input  wire logic        s_axi_rready
);

   eirq_state_s st;          // Registered state
   eirq_state_s next_st;     // Next state
   logic [7:0]  src_flag;    // Raw request flags, by polling index
   logic [7:0]  src_en;      // Per source enable, by polling index
   logic [7:0]  src_req;     // Enabled requests
   logic        arb_valid;   // Some enabled request exists
   logic [2:0]  arb_idx;     // Winning source
   logic [1:0]  arb_level;   // Winning level
   logic [7:0]  set_evt;     // Status set events this cycle
   logic [2:0]  next_top;    // Top active level of next state, with valid bit
   logic [2:0]  cur_top;     // Top active level of current state

   // Highest active level, valid bit on top
   function automatic logic [2:0] top_lvl(input logic [3:0] v);
      logic [2:0] t;
      t = 3'h0;
      for (int i = 0; i < 4; i++)
      begin
         if (v[i])
            t = {1'b1, 2'(i)};
      end
      return t;
   endfunction

   // Vector address of a source index
   function automatic logic [15:0] vec_of(input logic [2:0] idx);
      case (idx) // R09
         3'h0:    vec_of = `EIRQ_VEC_EXT0;
         3'h1:    vec_of = `EIRQ_VEC_TMR0;
         3'h2:    vec_of = `EIRQ_VEC_EXT1;
         3'h3:    vec_of = `EIRQ_VEC_TMR1;
         3'h4:    vec_of = `EIRQ_VEC_PCA;
         3'h5:    vec_of = `EIRQ_VEC_UART;
         3'h6:    vec_of = `EIRQ_VEC_SPI;
         default: vec_of = `EIRQ_VEC_CONV;
      endcase
   endfunction

   // Gather the eight sources in polling order; pins use the synchronised copy
   always_comb
   begin
      src_flag = {conv_req, spi_req, uart_rx_done | uart_tx_done,
                  pca_count_wrap_flag | pca_module_match_flag,
                  tmr1_ovf_flag, st.ext1_s2, tmr0_ovf_flag, st.ext0_s2}; // R01
      // Enable bits mapped from both enable registers
      src_en = {st.ie1[0], st.ie1[1], st.ie[`EIRQ_IE_UART],
                st.ie[`EIRQ_IE_PCA], st.ie[`EIRQ_IE_TMR1], st.ie[`EIRQ_IE_EXT1],
                st.ie[`EIRQ_IE_TMR0], st.ie[`EIRQ_IE_EXT0]}; // R10 R13
      // Global gate over the individual enables
      src_req = src_flag & src_en & {8{st.ie[`EIRQ_IE_GATE]}}; // R02 R03
   end

   // Winner among enabled requests
   eirq_pick u_pick
   (
      .req       (src_req),
      .lvl_lo    (st.lvl_lo),
      .lvl_hi    (st.lvl_hi),
      .win_valid (arb_valid),
      .win_idx   (arb_idx),
      .win_level (arb_level)
   );

   // Bus handshakes come straight from state, except read address ready, which also needs s_axi_awvalid low
   always_comb
   begin
      s_axi_awready = (st.ax == AX_IDLE) && !st.aw_got;
      s_axi_wready  = (st.ax == AX_IDLE) && !st.w_got;
      s_axi_arready = (st.ax == AX_IDLE) && !st.aw_got && !st.w_got && !s_axi_awvalid;
      s_axi_bvalid  = (st.ax == AX_WRSP);
      s_axi_rvalid  = (st.ax == AX_RDAT);
   end

   // Next state of the whole controller
   always_comb
   begin
      next_st  = st;
      set_evt  = 8'h00;
      cur_top  = top_lvl(st.in_service);
      // Pin synchronisers
      next_st.ext0_s1 = ext_pin0_req;
      next_st.ext0_s2 = st.ext0_s1;
      next_st.ext1_s1 = ext_pin1_req;
      next_st.ext1_s2 = st.ext1_s1;
      // Core takes the vector: mark its level active and log the event
      if (core_ack && st.req)
      begin
         next_st.in_service[st.level] = 1'b1; // R14
         set_evt[st.src]              = 1'b1;
      end
      // Return from handler ends the top active level
      else if (core_reti && cur_top[2])
      begin
         next_st.in_service[cur_top[1:0]] = 1'b0; // R14
      end
      // Capture write address and data, in either order
      if (s_axi_awvalid && s_axi_awready)
      begin
         next_st.aw_got = 1'b1;
         next_st.awaddr = s_axi_awaddr;
      end
      if (s_axi_wvalid && s_axi_wready)
      begin
         next_st.w_got = 1'b1;
         next_st.wdata = s_axi_wdata;
         next_st.wstrb = s_axi_wstrb;
      end
      case (st.ax)
         // Idle: perform a write once both halves are in, or take a read
         AX_IDLE:
         begin
            if (next_st.aw_got && next_st.w_got)
            begin
               next_st.aw_got = 1'b0;
               next_st.w_got  = 1'b0;
               next_st.ax     = AX_WRSP;
               next_st.resp   = `EIRQ_RESP_OKAY;
               case (next_st.awaddr)
                  `EIRQ_OFS_IE:
                     if (next_st.wstrb[0])
                        next_st.ie = next_st.wdata[7:0] & `EIRQ_IE_WMASK; // R10
                  `EIRQ_OFS_IE_SET:
                     if (next_st.wstrb[0])
                        next_st.ie = st.ie | (next_st.wdata[7:0] & `EIRQ_IE_WMASK); // R11
                  `EIRQ_OFS_IE_CLR:
                     if (next_st.wstrb[0])
                        next_st.ie = st.ie & ~next_st.wdata[7:0]; // R11
                  `EIRQ_OFS_IE1:
                     if (next_st.wstrb[0])
                        next_st.ie1 = next_st.wdata[`EIRQ_IE1_SPI:`EIRQ_IE1_CONV]; // R13
                  `EIRQ_OFS_LVL_LO:
                     if (next_st.wstrb[0])
                        next_st.lvl_lo = next_st.wdata[7:0];
                  `EIRQ_OFS_LVL_HI:
                     if (next_st.wstrb[0])
                        next_st.lvl_hi = next_st.wdata[7:0];
                  `EIRQ_OFS_STATUS:
                     if (next_st.wstrb[0])
                        next_st.status = st.status & ~next_st.wdata[7:0];
                  `EIRQ_OFS_MASK:
                     if (next_st.wstrb[0])
                        next_st.mask = next_st.wdata[7:0];
                  `EIRQ_OFS_ACTIVE:
                     next_st.resp = `EIRQ_RESP_OKAY;
                  default:
                     next_st.resp = `EIRQ_RESP_SLVERR;
               endcase
            end
            else if (s_axi_arvalid && s_axi_arready)
            begin
               next_st.ax    = AX_RDAT;
               next_st.resp  = `EIRQ_RESP_OKAY;
               next_st.rdata = 32'h0000_0000;
               case (s_axi_araddr)
                  // Reserved enable bit reads as zero
                  `EIRQ_OFS_IE,
                  `EIRQ_OFS_IE_SET,
                  `EIRQ_OFS_IE_CLR: next_st.rdata[7:0] = st.ie;
                  `EIRQ_OFS_IE1:    next_st.rdata[7:0] = {5'h00, st.ie1, 1'b0};
                  `EIRQ_OFS_LVL_LO: next_st.rdata[7:0] = st.lvl_lo;
                  `EIRQ_OFS_LVL_HI: next_st.rdata[7:0] = st.lvl_hi;
                  `EIRQ_OFS_STATUS: next_st.rdata[7:0] = st.status;
                  `EIRQ_OFS_MASK:   next_st.rdata[7:0] = st.mask;
                  // Live view of the core port and active levels
                  `EIRQ_OFS_ACTIVE: next_st.rdata = {4'h0, st.in_service, 2'h0, st.req,
                                                     st.level, st.src, st.vector};
                  default:          next_st.resp = `EIRQ_RESP_SLVERR;
               endcase
            end
         end
         // Write response held until taken
         AX_WRSP:
            if (s_axi_bready)
               next_st.ax = AX_IDLE;
         // Read data held until taken
         AX_RDAT:
            if (s_axi_rready)
               next_st.ax = AX_IDLE;
         default:
            next_st.ax = AX_IDLE;
      endcase
      // Hardware set after the clear, so a same cycle event survives
      next_st.status = next_st.status | set_evt;
      // Offer the winner only if it beats every active level
      next_top       = top_lvl(next_st.in_service);
      next_st.req    = arb_valid && !(core_ack && st.req)
                       && (!next_top[2] || (arb_level > next_top[1:0])); // R05 R14
      next_st.src    = arb_idx;
      next_st.level  = arb_level;
      next_st.vector = vec_of(arb_idx); // R09
   end

   // Register the whole state; enables and levels clear at reset
   always_ff @(posedge sys_clk)
   begin
      if (reset)
      begin
         st        <= '0;
         st.ie     <= `EIRQ_IE_RST; // R11
         st.ie1    <= `EIRQ_IE1_RST; // R11
         st.lvl_lo <= `EIRQ_LVL_RST;
         st.lvl_hi <= `EIRQ_LVL_RST;
         st.status <= `EIRQ_STAT_RST;
         st.mask   <= `EIRQ_MASK_RST;
         st.ax     <= AX_IDLE;
      end
      else
         st <= next_st;
   end

   // Outputs from state
   always_comb
   begin
      core_irq_req = st.req;
      core_vector  = st.vector;
      core_level   = st.level;
      core_src     = st.src;
      irq          = |(st.status & st.mask);
      s_axi_bresp  = st.resp;
      s_axi_rresp  = st.resp;
      s_axi_rdata  = st.rdata;
   end

   // Checking helpers: enables of the previous cycle and rivals of the winner
   logic [7:0] en_prev;      // Gated enables one cycle back
   logic [7:0] rival_higher; // Request above the winning level
   logic [7:0] rival_earlier; // Same level request with a lower index

   always_ff @(posedge sys_clk)
   begin
      en_prev <= src_en & {8{st.ie[`EIRQ_IE_GATE]}};
   end

   // Per source rival checks
   for (genvar g = 0; g < 8; g++)
   begin : g_rival
      assign rival_higher[g]  = src_req[g] && ({st.lvl_hi[g], st.lvl_lo[g]} > arb_level);
      assign rival_earlier[g] = src_req[g] && ({st.lvl_hi[g], st.lvl_lo[g]} == arb_level)
                                && (3'(g) < arb_idx);
   end

   default clocking cb @(posedge sys_clk);
   endclocking
   default disable iff (reset);

   gate_blocks_a: assert property (!st.ie[`EIRQ_IE_GATE] |=> !core_irq_req) // R03
      else $error("request offered while global gate clear");

   enable_blocks_a: assert property (core_irq_req |-> en_prev[core_src]) // R02
      else $error("request offered for disabled source");

   level_form_a: assert property (arb_valid |-> arb_level == {st.lvl_hi[arb_idx], // R04
                                                              st.lvl_lo[arb_idx]})
      else $error("winner level not formed from high and low bits");

   preempt_level_a: assert property (core_irq_req && cur_top[2] |-> // R05
                                     core_level > cur_top[1:0])
      else $error("request does not beat active level");

   higher_wins_a: assert property (arb_valid |-> rival_higher == 8'h00) // R06
      else $error("higher level request lost");

   poll_order_a: assert property (arb_valid |-> rival_earlier == 8'h00) // R07 R08
      else $error("polling order broken");

   vector_spi_a: assert property (core_irq_req && core_src == 3'h6 |-> // R09
                                  core_vector == 16'h004B)
      else $error("wrong vector for serial peripheral port");

   reset_clear_a: assert property ($past(reset) |-> st.ie == 8'h00 && st.ie1 == 2'h0) // R11
      else $error("enables not cleared by reset");

   active_track_a: assert property (core_ack && core_irq_req |=> // R14
                                    st.in_service[$past(core_level)] && !core_irq_req)
      else $error("active level not recorded on acknowledge");

   sticky_set_a: assert property (core_ack && core_irq_req |=>
                                  st.status[$past(core_src)] ##1 st.status[$past(core_src, 2)])
      else $error("status bit not set or not sticky");

   reserved_zero_a: assert property (st.ie[5] == 1'b0 ##1 st.ie[5] == 1'b0) // R10
      else $error("reserved enable bit stored");

   nest_cover_c: cover property (core_ack && core_irq_req ##[1:50] core_irq_req && cur_top[2]);

   tie_cover_c: cover property (arb_valid && $countones(src_req) > 1);

   return_cover_c: cover property (core_reti && cur_top[2]);

   bus_write_c: cover property (s_axi_bvalid && s_axi_bready);

endmodule

// ===== eirq_core_model.sv
// Core model that takes offered vectors and returns from handlers on command
`timescale 1ns/1ps
module eirq_core_model
   import eirq_pkg::*;
(
   // Clock and reset
   input  wire logic        sys_clk,
   input  wire logic        reset,
   // Offer from the controller
   input  wire logic        core_irq_req,
   input  wire logic [15:0] core_vector,
   input  wire logic [1:0]  core_level,
   input  wire logic [2:0]  core_src,
   // Commands from the bench
   input  wire logic        ack_en,
   input  wire logic [3:0]  ack_dly,
   input  wire logic        ret_req,
   // Answers to the controller
   output logic             core_ack,
   output logic             core_reti,
   // Last vector taken
   output logic [15:0]      got_vector,
   output logic [1:0]       got_level,
   output logic [2:0]       got_src,
   output logic [7:0]       got_cnt
);
   logic [3:0] wait_cnt;    // Cycles the current offer has stood

   // Ack after a chosen delay as a one cycle pulse; capture at the taking edge
   always_ff @(posedge sys_clk)
   begin
      if (reset)
      begin
         core_ack   <= 1'b0;
         core_reti  <= 1'b0;
         wait_cnt   <= 4'h0;
         got_vector <= 16'h0000;
         got_level  <= 2'h0;
         got_src    <= 3'h0;
         got_cnt    <= 8'h00;
      end
      else
      begin
         core_reti <= ret_req;
         if (core_ack)
         begin
            // An offer withdrawn under the ack is not counted
            core_ack <= 1'b0;
            wait_cnt <= 4'h0;
            if (core_irq_req)
            begin
               got_vector <= core_vector;
               got_level  <= core_level;
               got_src    <= core_src;
               got_cnt    <= got_cnt + 8'h01;
            end
         end
         else if (core_irq_req && ack_en && wait_cnt >= ack_dly)
            core_ack <= 1'b1;
         else if (core_irq_req)
            wait_cnt <= wait_cnt + 4'h1;
         else
            wait_cnt <= 4'h0;
      end
   end
endmodule

// ===== tb.sv
// Self-checking bench for the interrupt controller
`timescale 1ns/1ps
`include "eirq_defs.svh"
module tb;
   import eirq_pkg::*;
   logic        sys_clk, reset, ack_en, ret_req, core_ack, core_reti, irq;
   logic        core_irq_req;
   logic [7:0]  flags, lo, hi;     // Requests and levels by polling index
   logic [1:0]  pick;              // Which flag of a pair carries the request
   logic [15:0] core_vector, got_vector;
   logic [1:0]  core_level, got_level, rd_resp, wr_resp;
   logic [2:0]  core_src, got_src, w;
   logic [3:0]  ack_dly;
   logic [7:0]  got_cnt, awaddr, araddr;
   logic [31:0] wdata, rdata, rd_data, seed, errors, check_count;
   logic [3:0]  wstrb;
   logic        awvalid, awready, wvalid, wready, bvalid, bready;
   logic        arvalid, arready, rvalid, rready;
   logic [1:0]  bresp, rresp;
   logic [15:0] vecs [8] = '{`EIRQ_VEC_EXT0, `EIRQ_VEC_TMR0, `EIRQ_VEC_EXT1, `EIRQ_VEC_TMR1,
                             `EIRQ_VEC_PCA, `EIRQ_VEC_UART, `EIRQ_VEC_SPI, `EIRQ_VEC_CONV};

   eirq_ctrl i_dut (.sys_clk(sys_clk), .reset(reset),
      .ext_pin0_req(flags[0]), .tmr0_ovf_flag(flags[1]), .ext_pin1_req(flags[2]),
      .tmr1_ovf_flag(flags[3]), .pca_count_wrap_flag(flags[4] & pick[0]),
      .pca_module_match_flag(flags[4] & ~pick[0]), .uart_rx_done(flags[5] & pick[1]),
      .uart_tx_done(flags[5] & ~pick[1]), .spi_req(flags[6]), .conv_req(flags[7]),
      .core_irq_req(core_irq_req), .core_vector(core_vector), .core_level(core_level),
      .core_src(core_src), .core_ack(core_ack), .core_reti(core_reti), .irq(irq),
      .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
      .s_axi_wdata(wdata), .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
      .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
      .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
      .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready));

   eirq_core_model i_core (.sys_clk(sys_clk), .reset(reset), .core_irq_req(core_irq_req),
      .core_vector(core_vector), .core_level(core_level), .core_src(core_src),
      .ack_en(ack_en), .ack_dly(ack_dly), .ret_req(ret_req), .core_ack(core_ack),
      .core_reti(core_reti), .got_vector(got_vector), .got_level(got_level),
      .got_src(got_src), .got_cnt(got_cnt));

   // Next random value
   function automatic logic [31:0] lfsr(input logic [31:0] s);
      return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
   endfunction

   // Expected winner: highest level, then lowest polling index
   function automatic logic [2:0] exp_pick(input logic [7:0] f, l, h);
      logic [2:0] r;
      logic [2:0] best;
      r = 3'h0;
      best = 3'h0;
      for (int i = 0; i < 8; i++)
         if (f[i] && {1'b1, h[i], l[i]} > best)
         begin
            r = i[2:0];
            best = {1'b1, h[i], l[i]};
         end
      return r;
   endfunction

   // Whether a pending request stands above a given level
   function automatic logic higher(input logic [7:0] f, l, h, input logic [1:0] lv);
      logic any;
      any = 1'b0;
      for (int i = 0; i < 8; i++)
         if (f[i] && {h[i], l[i]} > lv)
            any = 1'b1;
      return any;
   endfunction

   // Compare and report
   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
      check_count++;
      if (seen !== exp)
      begin
         errors++;
         $display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
      end
   endtask

   // Print counts and verdict, end the run
   task automatic summarize;
      $display("checks %0d errors %0d", check_count, errors);
      if (errors == 0 && check_count > 0)
         $display("== PASSED ==");
      else
         $display("== FAILED ==");
      $finish;
   endtask

   // Register write: address and data offered together, each released when taken
   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      logic da, dw;
      int   n;
      da = 1'b0;
      dw = 1'b0;
      n = 0;
      @(posedge sys_clk);
      awaddr <= a;
      wdata <= d;
      wstrb <= 4'hF;
      awvalid <= 1'b1;
      wvalid <= 1'b1;
      bready <= 1'b1;
      while (!(da && dw && bvalid) && n < 200)
      begin
         @(negedge sys_clk);
         da = da | awready;
         dw = dw | wready;
         n++;
         if (!(da && dw && bvalid))
         begin
            @(posedge sys_clk);
            if (da) awvalid <= 1'b0;
            if (dw) wvalid <= 1'b0;
         end
      end
      wr_resp = bresp;
      @(posedge sys_clk);
      bready <= 1'b0;
      if (n >= 200) errors++;
   endtask

   // Register read: data and response land in rd_data and rd_resp
   task automatic rd(input logic [7:0] a);
      logic da;
      int   n;
      da = 1'b0;
      n = 0;
      @(posedge sys_clk);
      araddr <= a;
      arvalid <= 1'b1;
      rready <= 1'b1;
      while (!(da && rvalid) && n < 200)
      begin
         @(negedge sys_clk);
         da = da | arready;
         n++;
         if (!(da && rvalid))
         begin
            @(posedge sys_clk);
            if (da) arvalid <= 1'b0;
         end
      end
      rd_data = rdata;
      rd_resp = rresp;
      @(posedge sys_clk);
      rready <= 1'b0;
      if (n >= 200) errors++;
   endtask

   // Wait until the core model counts a new taken vector
   task automatic wait_ack;
      logic [7:0] old;
      int         n;
      old = got_cnt;
      n = 0;
      while (got_cnt === old && n < 100)
      begin
         @(negedge sys_clk);
         n++;
      end
      if (n >= 100) errors++;
   endtask

   // No offer may appear for eight cycles
   task automatic quiet;
      logic [31:0] hits;
      hits = 32'h0;
      repeat (8)
      begin
         @(negedge sys_clk);
         hits = hits + {31'h0, core_irq_req};
      end
      check(hits, 32'h0);
   endtask

   // Pulse return from handler after the released flags have settled
   task automatic reti_pulse;
      repeat (4) @(posedge sys_clk);
      ret_req <= 1'b1;
      @(posedge sys_clk);
      ret_req <= 1'b0;
   endtask

   // Clock
   initial
   begin
      sys_clk = 1'b0;
      forever #50 sys_clk = ~sys_clk;
   end

   // Watchdog
   initial
   begin
      repeat (30000) @(posedge sys_clk);
      errors++;
      summarize();
   end

   // Main sequence
   initial
   begin
      {reset, flags, pick, ack_en, ack_dly, ret_req, lo, hi} = {1'b1, 32'h0};
      {awaddr, wdata, wstrb, awvalid, wvalid, bready, araddr, arvalid, rready} = 0;
      {errors, check_count, seed} = {64'h0, 32'h85F5};
      repeat (2) @(posedge sys_clk);
      reset <= 1'b0;
      // Reset values, layout, bit access, unmapped place
      rd(`EIRQ_OFS_IE);  check(rd_data, 32'h0);
      rd(`EIRQ_OFS_IE1); check(rd_data, 32'h0);
      rd(8'hF0);         wr(8'hF0, 32'h0);
      check({rd_data[27:0], rd_resp, wr_resp}, {28'h0, `EIRQ_RESP_SLVERR, `EIRQ_RESP_SLVERR});
      wr(`EIRQ_OFS_IE, 32'hDF); rd(`EIRQ_OFS_IE); check(rd_data, 32'hDF);
      wr(`EIRQ_OFS_IE_CLR, 32'hDF); wr(`EIRQ_OFS_IE_SET, 32'h02);
      rd(`EIRQ_OFS_IE);  check(rd_data, 32'h02);
      wr(`EIRQ_OFS_IE1, 32'h06); rd(`EIRQ_OFS_IE1); check(rd_data, 32'h06);
      // Gate cleared with every source enabled, then gate alone
      wr(`EIRQ_OFS_IE, 32'h5F);
      flags <= 8'hFF;
      pick <= seed[1:0];
      quiet();
      wr(`EIRQ_OFS_IE, 32'h80); wr(`EIRQ_OFS_IE1, 32'h00);
      quiet();
      wr(`EIRQ_OFS_IE1, 32'h06); wr(`EIRQ_OFS_IE, 32'hDF);
      ack_en <= 1'b1;
      // All at level zero: polling order, vectors, no same-level preemption
      for (int k = 0; k < 8; k++)
      begin
         seed = lfsr(seed);
         ack_dly <= seed[3:0];
         wait_ack();
         check({got_level, got_src, got_vector}, {2'h0, k[2:0], vecs[k]});
         repeat (4) @(negedge sys_clk);
         check({31'h0, core_irq_req}, 32'h0);
         @(posedge sys_clk);
         flags[k] <= 1'b0;
         reti_pulse();
      end
      // Events, mask and interrupt output
      rd(`EIRQ_OFS_STATUS); check(rd_data, 32'hFF);
      @(negedge sys_clk); check({31'h0, irq}, 32'h0);
      wr(`EIRQ_OFS_MASK, 32'h02); @(negedge sys_clk); check({31'h0, irq}, 32'h1);
      wr(`EIRQ_OFS_STATUS, 32'h02); @(negedge sys_clk); check({31'h0, irq}, 32'h0);
      rd(`EIRQ_OFS_STATUS); check(rd_data, 32'hFD);
      // Random levels and requests: winner, level and preemption
      ack_en <= 1'b0;
      repeat (12)
      begin
         seed = lfsr(seed);
         lo = seed[7:0];
         hi = seed[15:8];
         wr(`EIRQ_OFS_LVL_LO, {24'h0, lo}); wr(`EIRQ_OFS_LVL_HI, {24'h0, hi});
         @(posedge sys_clk);
         flags <= (seed[23:16] == 8'h00) ? 8'h80 : seed[23:16];
         pick <= seed[25:24];
         ack_dly <= seed[29:26];
         repeat (4) @(posedge sys_clk);
         ack_en <= 1'b1;
         wait_ack();
         @(posedge sys_clk);
         ack_en <= 1'b0;
         w = exp_pick(flags, lo, hi);
         check({got_src, got_vector}, {w, vecs[w]});
         check({30'h0, got_level}, {30'h0, hi[w], lo[w]});
         flags <= ~flags;
         repeat (4) @(negedge sys_clk);
         check({31'h0, core_irq_req}, {31'h0, higher(flags, lo, hi, {hi[w], lo[w]})});
         @(posedge sys_clk);
         flags <= 8'h00;
         reti_pulse();
      end
      repeat (4) @(posedge sys_clk);
      summarize();
   end
endmodule
